// file: design/amc_mode_ctrl.sv
// What this block does
// RL1: With the buffer bit clear the common negative input is left unbuffered, set routes it through the buffer.
// RL2: With the reference select bit clear the first reference pair is used, set uses the second pair.
// RL3: The channel arrangement bit overrides reference select, so ten-input mode always uses one pair.
// RL4: Arrangement bit clear gives eight inputs with two reference choices, set gives ten with one.
// RL5: With the oscillator-off bit set, entering standby also stops the crystal oscillator.
// RL6: After standby with the oscillator stopped, 300 ms of restart pass before normal operation.
// RL7: With the oscillator-off bit clear the oscillator keeps running in standby and resumes at once.
// RL8: The chop bit enables chopping when clear and disables it when set, enabled after reset.
// RL9: The configuration bits sit in a host-writable register that holds until rewritten or reset.
`timescale 1ns/1ps
`default_nettype none

module amc_mode_ctrl
  import amc_pkg::*;
#(
  parameter int unsigned OSC_START_CYCLES = AMC_OSC_START_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [AMC_ADDR_W-1:0] reg_addr_i,
  input wire logic [AMC_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [AMC_DATA_W-1:0] reg_rdata_o,
  output amc_route_type route_o,
  output logic osc_enable_o,
  output logic standby_o,
  output logic device_ready_o
);

  amc_mode_type mode_r;
  amc_route_type route_nxt;
  amc_route_type route_r;
  amc_osc_state_type osc_state_r;
  amc_osc_state_type osc_state_nxt;
  logic osc_en_r;
  logic ready_r;
  logic standby_r;
  logic [AMC_DATA_W-1:0] rdata_r;
  logic standby_req;
  logic osc_off_req;
  logic tmr_run;
  logic tmr_done;
  logic mode_wr;
  logic [AMC_DATA_W-1:0] status_val;
  localparam logic [AMC_TMR_W-1:0] RESTART_LAST = AMC_TMR_W'(OSC_START_CYCLES - 1);
  logic [AMC_TMR_W-1:0] restart_seen_r;

  assign mode_wr = reg_wr_i && (reg_addr_i == AMC_MODE_OFS);
  assign standby_req = (mode_r.conv_mode == AMC_MD_STANDBY);
  assign osc_off_req = standby_req && mode_r.oscillator_off_in_standby;

  // RL9: host mode register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= amc_mode_type'(AMC_MODE_RST);
    end else if (mode_wr) begin
      mode_r <= amc_mode_type'(reg_wdata_i);
    end
  end

  amc_route_decode u_decode (
    .mode_i(mode_r),
    .route_o(route_nxt)
  );

  // RL1: registered analog routing
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      route_r <= amc_route_type'(AMC_ROUTE_RST);
    end else begin
      route_r <= route_nxt;
    end
  end

  assign route_o = route_r;

  assign tmr_run = (osc_state_r == OSC_STARTING);

  amc_startup_timer #(
    .CYCLES(OSC_START_CYCLES)
  ) u_timer (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(tmr_run),
    .done_o(tmr_done)
  );

  // Oscillator power sequencing
  always_comb begin
    osc_state_nxt = osc_state_r;
    case (osc_state_r)
      OSC_RUN: begin
        // RL5: stop in standby
        if (osc_off_req) begin
          osc_state_nxt = OSC_STOPPED;
        end
      end
      OSC_STOPPED: begin
        // RL6: restart wait begins
        if (!osc_off_req) begin
          osc_state_nxt = OSC_STARTING;
        end
      end
      OSC_STARTING: begin
        if (osc_off_req) begin
          osc_state_nxt = OSC_STOPPED;
        end else if (tmr_done) begin
          osc_state_nxt = OSC_RUN;
        end
      end
      default: begin
        osc_state_nxt = OSC_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_state_r <= OSC_RUN;
    end else begin
      osc_state_r <= osc_state_nxt;
    end
  end

  // RL7: oscillator stays on unless stopped
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_en_r <= 1'b1;
      ready_r <= 1'b1;
      standby_r <= 1'b0;
    end else begin
      osc_en_r <= (osc_state_nxt != OSC_STOPPED);
      ready_r <= (osc_state_nxt == OSC_RUN) && !standby_req;
      standby_r <= standby_req;
    end
  end

  assign osc_enable_o = osc_en_r;
  assign device_ready_o = ready_r;
  assign standby_o = standby_r;

  always_comb begin
    status_val = '0;
    status_val[AMC_ST_STANDBY_POS] = standby_r;
    status_val[AMC_ST_OSC_ON_POS] = osc_en_r;
    status_val[AMC_ST_READY_POS] = ready_r;
    status_val[AMC_ST_STARTING_POS] = tmr_run;
  end

  // Read data stands for one cycle only
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= AMC_RD_IDLE;
    end else if (!reg_rd_i) begin
      rdata_r <= AMC_RD_IDLE;
    end else if (reg_addr_i == AMC_MODE_OFS) begin
      rdata_r <= mode_r;
    end else if (reg_addr_i == AMC_STAT_OFS) begin
      rdata_r <= status_val;
    end else begin
      rdata_r <= AMC_RD_IDLE;
    end
  end

  assign reg_rdata_o = rdata_r;

  // RL6: independent restart count
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      restart_seen_r <= '0;
    end else if (osc_state_r != OSC_STARTING) begin
      restart_seen_r <= '0;
    end else begin
      restart_seen_r <= restart_seen_r + 1'b1;
    end
  end

  default clocking dflt_cb @(posedge ref_clk_i);
  endclocking

  default disable iff (!rst_n_i);

  mode_write_a: assert property ( // RL9
    mode_wr |=> (mode_r == $past(reg_wdata_i))
  ) else $error("mode register missed a write");

  mode_hold_a: assert property ( // RL9
    !mode_wr |=> $stable(mode_r)
  ) else $error("mode register changed without a write");

  buffer_route_a: assert property ( // RL1
    mode_wr ##1 1'b1 |=>
      (route_o.common_buffer_on == $past(reg_wdata_i[AMC_BUF_EN_POS], 2))
  ) else $error("buffer routing does not follow the buffer bit");

  ref_first_a: assert property ( // RL2
    (!mode_r.channel_arrangement_select && !mode_r.reference_pair_select)
      |=> (route_o.first_reference_pair && !route_o.second_reference_pair)
  ) else $error("first reference pair not chosen");

  ref_second_a: assert property ( // RL2
    (!mode_r.channel_arrangement_select && mode_r.reference_pair_select)
      |=> (route_o.second_reference_pair && !route_o.first_reference_pair)
  ) else $error("second reference pair not chosen");

  ten_input_a: assert property ( // RL3
    mode_r.channel_arrangement_select
      |=> (route_o.ten_input_arrangement && route_o.first_reference_pair
           && !route_o.second_reference_pair)
  ) else $error("ten-input mode let reference select through");

  eight_input_a: assert property ( // RL4
    !mode_r.channel_arrangement_select |=> !route_o.ten_input_arrangement
  ) else $error("eight-input arrangement not selected");

  chop_ctrl_a: assert property ( // RL8
    ##1 (route_o.chop_enable == !$past(mode_r.chop_disable))
  ) else $error("chop enable does not follow the chop bit");

  osc_stop_a: assert property ( // RL5
    (osc_state_r == OSC_RUN && osc_off_req) |=> (!osc_enable_o ##1 !device_ready_o)
  ) else $error("oscillator kept running in standby");

  osc_keep_a: assert property ( // RL7
    (osc_state_r == OSC_RUN && !mode_r.oscillator_off_in_standby)
      |=> (osc_enable_o && osc_state_r == OSC_RUN)
  ) else $error("oscillator stopped although it should run");

  restart_wait_a: assert property ( // RL6
    (osc_state_r == OSC_STARTING && !tmr_done) |=> (osc_state_r != OSC_RUN)
  ) else $error("oscillator declared running before restart time");

  restart_ready_a: assert property ( // RL6
    (osc_state_r == OSC_STOPPED && !osc_off_req)
      |=> (osc_state_r == OSC_STARTING && !device_ready_o)
  ) else $error("leaving standby skipped the restart wait");

  read_mode_a: assert property ( // RL9
    (reg_rd_i && reg_addr_i == AMC_MODE_OFS) |=> (reg_rdata_o == $past(mode_r))
  ) else $error("mode register read back wrong");

  read_status_a: assert property ( // RL9
    (reg_rd_i && reg_addr_i == AMC_STAT_OFS) |=> (reg_rdata_o == $past(status_val))
  ) else $error("status register read back wrong");

  read_unmapped_a: assert property ( // RL9
    (reg_rd_i && reg_addr_i != AMC_MODE_OFS && reg_addr_i != AMC_STAT_OFS)
      |=> (reg_rdata_o == AMC_RD_IDLE)
  ) else $error("unmapped read returned data");

  read_idle_a: assert property ( // RL9
    !reg_rd_i |=> (reg_rdata_o == AMC_RD_IDLE)
  ) else $error("read data stood without a read");

  write_ignored_a: assert property ( // RL9
    (reg_wr_i && reg_addr_i != AMC_MODE_OFS) |=> $stable(mode_r)
  ) else $error("write to another address changed the mode register");

  ref_one_pair_a: assert property ( // RL2
    route_o.first_reference_pair != route_o.second_reference_pair
  ) else $error("reference pair choice not exclusive");

  standby_flag_a: assert property ( // RL5
    1'b1 |=> (standby_o == $past(standby_req))
  ) else $error("standby flag does not follow the mode");

  ready_standby_a: assert property ( // RL5
    standby_o |-> !device_ready_o
  ) else $error("device ready while in standby");

  osc_off_state_a: assert property ( // RL5
    (osc_state_r == OSC_STOPPED) |-> !osc_enable_o
  ) else $error("oscillator enabled while stopped");

  restart_osc_on_a: assert property ( // RL6
    (osc_state_r == OSC_STARTING) |-> (osc_enable_o && !device_ready_o)
  ) else $error("restart state with wrong oscillator or ready");

  restart_end_a: assert property ( // RL6
    (osc_state_r == OSC_STARTING && tmr_done && !standby_req)
      |=> (osc_state_r == OSC_RUN && device_ready_o)
  ) else $error("restart did not end in normal operation");

  restart_length_a: assert property ( // RL6
    (osc_state_r == OSC_STARTING && osc_state_nxt == OSC_RUN) |-> (restart_seen_r == RESTART_LAST)
  ) else $error("restart time differs from the start-up count");

  resume_fast_a: assert property ( // RL7
    (osc_state_r == OSC_RUN && !standby_req) |=> device_ready_o
  ) else $error("running oscillator did not resume at once");

  stop_cover_c: cover property (
    osc_state_r == OSC_STOPPED ##1 osc_state_r == OSC_STARTING
  );

  restart_cover_c: cover property (
    osc_state_r == OSC_STARTING ##1 osc_state_r == OSC_RUN
  );

  ten_input_cover_c: cover property (
    route_o.ten_input_arrangement && mode_r.reference_pair_select
  );

  standby_run_cover_c: cover property (
    standby_r && osc_enable_o && !mode_r.oscillator_off_in_standby
  );

  ref_second_cover_c: cover property (
    route_o.second_reference_pair && !route_o.ten_input_arrangement
  );

endmodule : amc_mode_ctrl

`default_nettype wire

// file: common/amc_pkg.sv
package amc_pkg;

  // Register port
  localparam int unsigned AMC_ADDR_W = 4;
  localparam int unsigned AMC_DATA_W = 8;
  localparam logic [3:0] AMC_MODE_OFS = 4'h0;
  localparam logic [3:0] AMC_STAT_OFS = 4'h1;
  localparam logic [7:0] AMC_MODE_RST = 8'h00;
  localparam logic [7:0] AMC_RD_IDLE = 8'h00;
  // Routing after reset: buffer off, first pair, eight inputs, chop on
  localparam logic [4:0] AMC_ROUTE_RST = 5'h09;

  // Mode register field positions
  localparam int unsigned AMC_CHOP_DIS_POS = 7;
  localparam int unsigned AMC_BUF_EN_POS = 6;
  localparam int unsigned AMC_REF_SEL_POS = 5;
  localparam int unsigned AMC_CH_ARR_POS = 4;
  localparam int unsigned AMC_OSC_OFF_POS = 3;
  localparam int unsigned AMC_CONV_MODE_POS = 0;

  // Status register field positions
  localparam int unsigned AMC_ST_STANDBY_POS = 0;
  localparam int unsigned AMC_ST_OSC_ON_POS = 1;
  localparam int unsigned AMC_ST_READY_POS = 2;
  localparam int unsigned AMC_ST_STARTING_POS = 3;

  // Conversion mode code that puts the converter in standby
  localparam logic [2:0] AMC_MD_STANDBY = 3'h1;

  // Oscillator restart time
  localparam int unsigned AMC_CLK_KHZ = 250000;
  localparam int unsigned AMC_OSC_START_MS = 300;
  localparam int unsigned AMC_OSC_START_CYCLES = AMC_OSC_START_MS * AMC_CLK_KHZ;
  localparam int unsigned AMC_TMR_W = 27;

  typedef struct packed {
    logic chop_disable;
    logic common_input_buffer_enable;
    logic reference_pair_select;
    logic channel_arrangement_select;
    logic oscillator_off_in_standby;
    logic [2:0] conv_mode;
  } amc_mode_type;

  typedef struct packed {
    logic common_buffer_on;
    logic first_reference_pair;
    logic second_reference_pair;
    logic ten_input_arrangement;
    logic chop_enable;
  } amc_route_type;

  typedef enum logic [1:0] {
    OSC_RUN,
    OSC_STOPPED,
    OSC_STARTING
  } amc_osc_state_type;

endpackage : amc_pkg

// file: design/amc_route_decode.sv
`timescale 1ns/1ps
`default_nettype none

module amc_route_decode
  import amc_pkg::*;
(
  input wire amc_mode_type mode_i,
  output amc_route_type route_o
);

  always_comb begin
    // RL1: common input buffer
    route_o.common_buffer_on = mode_i.common_input_buffer_enable;
    // RL4: channel arrangement
    route_o.ten_input_arrangement = mode_i.channel_arrangement_select;
    // RL3: arrangement overrides selection
    if (mode_i.channel_arrangement_select) begin
      route_o.first_reference_pair = 1'b1;
      route_o.second_reference_pair = 1'b0;
    end else begin
      // RL2: reference pair choice
      route_o.first_reference_pair = ~mode_i.reference_pair_select;
      route_o.second_reference_pair = mode_i.reference_pair_select;
    end
    // RL8: chop when bit clear
    route_o.chop_enable = ~mode_i.chop_disable;
  end

endmodule : amc_route_decode

`default_nettype wire

// file: design/amc_startup_timer.sv
`timescale 1ns/1ps
`default_nettype none

module amc_startup_timer
  import amc_pkg::*;
#(
  parameter int unsigned CYCLES = AMC_OSC_START_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  output logic done_o
);

  localparam logic [AMC_TMR_W-1:0] LAST = AMC_TMR_W'(CYCLES - 1);

  logic [AMC_TMR_W-1:0] count_r;

  // Counts while running, restarts from zero whenever stopped
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= '0;
    end else if (!run_i) begin
      count_r <= '0;
    end else if (count_r != LAST) begin
      count_r <= count_r + 1'b1;
    end
  end

  assign done_o = run_i && (count_r == LAST);

endmodule : amc_startup_timer

`default_nettype wire

// file: test/amc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module amc_host_model
  import amc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic ready_i,
  input wire logic [AMC_DATA_W-1:0] rdata_i,
  output logic [AMC_ADDR_W-1:0] addr_o,
  output logic [AMC_DATA_W-1:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 4'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // Released lines show the inverse of the last value
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
    @(posedge ref_clk_i);
    addr_o <= addr;
    wdata_o <= data;
    wr_o <= 1'b1;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~addr;
    wdata_o <= ~data;
  endtask : write_reg

  task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
    @(posedge ref_clk_i);
    addr_o <= addr;
    rd_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~addr;
    #1;
    data = rdata_i;
  endtask : read_reg

  task automatic wait_ready(input int limit, output int cycles);
    cycles = 0;
    while (ready_i !== 1'b1 && cycles < limit) begin
      @(posedge ref_clk_i);
      #1;
      cycles++;
    end
  endtask : wait_ready
endmodule : amc_host_model

`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import amc_pkg::*;
  localparam int unsigned START_CYC = 16;
  logic ref_clk;
  logic rst_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rd_val;
  logic wr;
  logic rd;
  logic osc;
  logic stb;
  logic rdy;
  amc_route_type route;
  int fail_count = 0;
  int num_checks = 0;

  amc_mode_ctrl #(.OSC_START_CYCLES(START_CYC)) i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .route_o(route), .osc_enable_o(osc), .standby_o(stb), .device_ready_o(rdy));

  amc_host_model i_host (.ref_clk_i(ref_clk), .ready_i(rdy), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic settle;
    @(posedge ref_clk);
    #1;
  endtask : settle

  function automatic logic [7:0] route_exp(input logic [7:0] m);
    logic ten;
    logic sel;
    ten = m[AMC_CH_ARR_POS];
    sel = m[AMC_REF_SEL_POS];
    route_exp = {3'h0, m[AMC_BUF_EN_POS], ten | ~sel, ~ten & sel, ten, ~m[AMC_CHOP_DIS_POS]};
  endfunction : route_exp

  task automatic test_reset;
    #1;
    check("reset route", {3'h0, route}, 8'h09);
    check("reset osc", {5'h0, osc, stb, rdy}, 8'h05);
    i_host.read_reg(AMC_MODE_OFS, rd_val);
    check("reset mode", rd_val, AMC_MODE_RST);
  endtask : test_reset

  task automatic test_route;
    logic [7:0] m;
    for (int v = 0; v < 16; v++) begin
      m = {v[3:0], 4'h0};
      i_host.write_reg(AMC_MODE_OFS, m);
      settle();
      check("route", {3'h0, route}, route_exp(m));
    end
    i_host.read_reg(AMC_MODE_OFS, rd_val);
    check("mode hold", rd_val, 8'hf0);
  endtask : test_route

  task automatic test_regs;
    i_host.write_reg(AMC_MODE_OFS, 8'h5a);
    i_host.write_reg(4'h3, 8'hff);
    i_host.write_reg(AMC_STAT_OFS, 8'hff);
    i_host.read_reg(AMC_MODE_OFS, rd_val);
    check("mode rw", rd_val, 8'h5a);
    settle();
    check("rdata idle", rdata, AMC_RD_IDLE);
    i_host.read_reg(4'h7, rd_val);
    check("unmapped", rd_val, 8'h00);
    i_host.read_reg(AMC_STAT_OFS, rd_val);
    check("status run", rd_val, 8'h06);
  endtask : test_regs

  task automatic test_osc_stop;
    int n;
    i_host.write_reg(AMC_MODE_OFS, 8'h09);
    settle();
    check("osc stopped", {5'h0, osc, stb, rdy}, 8'h02);
    i_host.read_reg(AMC_STAT_OFS, rd_val);
    check("status stop", rd_val, 8'h01);
    i_host.write_reg(AMC_MODE_OFS, 8'h08);
    settle();
    check("osc restart", {5'h0, osc, stb, rdy}, 8'h04);
    i_host.read_reg(AMC_STAT_OFS, rd_val);
    check("status restart", rd_val, 8'h0a);
    i_host.wait_ready(START_CYC + 8, n);
    check("ready after", {5'h0, osc, stb, rdy}, 8'h05);
    check("restart long", {7'h0, n >= 12}, 8'h01);
  endtask : test_osc_stop

  task automatic test_osc_keep;
    i_host.write_reg(AMC_MODE_OFS, 8'h01);
    settle();
    check("osc kept", {5'h0, osc, stb, rdy}, 8'h06);
    i_host.write_reg(AMC_MODE_OFS, 8'h00);
    settle();
    check("ready at once", {5'h0, osc, stb, rdy}, 8'h05);
  endtask : test_osc_keep

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_reset();
    test_route();
    test_regs();
    test_osc_stop();
    test_osc_keep();
    summarize();
  end
endmodule : testbench

`default_nettype wire
